/* File: core/npec_ctrl.sv */
// Purpose: control/address registers and sequencer of the flash
//          program/erase controller
// Assumes: array reports done; reset_n arrives already synchronised to clk
// Notes:   reset_n is power-on/brown-out reset; other resets leave state
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module npec_ctrl #(
   parameter int SETTLE_CYCLES = npec_pkg::SETTLE_CYCLES
) (
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // register port
   input  wire logic [1:0]       reg_addr,
   input  wire logic [15:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output var  logic [15:0]      reg_rdata,
   // system reset other than power-on (pin, async to block)
   input  wire logic             sys_reset_req,
   // power state (pins)
   input  wire logic             idle_mode,
   input  wire logic             power_save_req,
   output var  logic             power_save_ack,
   // flash array
   output var  logic             nvm_start,
   output var  logic [3:0]       nvm_op,
   output var  logic [23:0]      nvm_addr,
   output var  logic             nvm_halt,
   output var  logic             nvm_ready,
   input  wire logic             nvm_done,
   input  wire logic             nvm_abnormal
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_HALT = 3'b100
   } npec_state_t;

   npec_state_t      state;
   npec_state_t      next_state;

   logic             go;
   logic             enable;
   logic             fault;
   logic             halt_in_idle_bit;
   logic [3:0]       operation_select;
   logic [7:0]       target_upper_addr;
   logic [15:0]      target_lower_addr;
   logic [1:0]       key_stage;
   logic             unlocked;
   logic [npec_pkg::CNT_W-1:0] settle_cnt;

   logic [2:0]       idle_sync;
   logic [1:0]       psave_sync;
   logic [1:0]       sreset_sync;
   logic [1:0]       done_sync;
   logic [1:0]       abn_sync;

   npec_pkg::npec_bus_t bus;
   assign bus = '{addr: reg_addr, wdata: reg_wdata,
                  wr: reg_wr, rd: reg_rd};

   function automatic logic op_valid(input logic [3:0] op);
      op_valid = (op == npec_pkg::OP_BULK_PRIMARY) ||
                 (op == npec_pkg::OP_BULK_AUX) ||
                 (op == npec_pkg::OP_PAGE_ERASE) ||
                 (op == npec_pkg::OP_ROW_PROGRAM) ||
                 (op == npec_pkg::OP_DWORD_PROG) ||
                 (op == npec_pkg::OP_CONFIG_BYTE);
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         idle_sync   <= 3'h0;
         psave_sync  <= 2'h0;
         sreset_sync <= 2'h0;
         done_sync   <= 2'h0;
         abn_sync    <= 2'h0;
      end else if (clk_en) begin
         idle_sync   <= {idle_sync[1:0], idle_mode};
         psave_sync  <= {psave_sync[0], power_save_req};
         sreset_sync <= {sreset_sync[0], sys_reset_req};
         done_sync   <= {done_sync[0], nvm_done};
         abn_sync    <= {abn_sync[0], nvm_abnormal};
      end
   end

   wire idle_s     = idle_sync[1];
   wire idle_exit  = idle_sync[2] & ~idle_sync[1];
   wire psave_s    = psave_sync[1];
   wire soft_reset = sreset_sync[1];
   wire done_s     = done_sync[1];
   wire abn_s      = abn_sync[1];

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire wr_ctrl  = bus.wr & (bus.addr == npec_pkg::ADDR_CONTROL);
   wire wr_upper = bus.wr & (bus.addr == npec_pkg::ADDR_TGT_UPPER);
   wire wr_lower = bus.wr & (bus.addr == npec_pkg::ADDR_TGT_LOWER);
   wire wr_key   = bus.wr & (bus.addr == npec_pkg::ADDR_UNLOCK_KEY);
   wire go_req   = wr_ctrl & bus.wdata[npec_pkg::BIT_GO] & ~go;
   // launch needs the one-cycle unlock window and a valid setup
   wire go_ok    = go_req & unlocked & enable
                   & op_valid(operation_select);
   wire go_bad   = go_req & ~go_ok;
   wire settling = (settle_cnt != '0);
   wire op_end   = (state == ST_RUN) & (done_s | abn_s);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (go_ok) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (done_s | abn_s) begin
               next_state = ST_IDLE;
            end else if (idle_s & halt_in_idle_bit) begin
               next_state = ST_HALT;
            end
         end
         ST_HALT: begin
            if (!idle_s && !settling && !idle_exit) begin
               next_state = ST_RUN;
            end
         end
      endcase
   end

   // async reset is power-on/brown-out: aborts any operation
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // control register; other reset sources leave these untouched
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         go               <= 1'b0;
         enable           <= 1'b0;
         fault            <= 1'b0;
         halt_in_idle_bit <= 1'b0;
         operation_select <= npec_pkg::OP_RESET;
      end else if (clk_en) begin
         // only a one is taken into go
         if (go_ok) begin
            go <= 1'b1;
         end else if (op_end) begin
            go <= 1'b0;
         end
         // hardware set beats a software write
         if (go_bad || (op_end && abn_s)) begin
            fault <= 1'b1;
         end else if (wr_ctrl) begin
            fault <= bus.wdata[npec_pkg::BIT_FAULT];
         end
         if (wr_ctrl && !go) begin
            enable           <= bus.wdata[npec_pkg::BIT_ENABLE];
            halt_in_idle_bit <= bus.wdata[npec_pkg::BIT_HALT_IDLE];
            operation_select <= bus.wdata[npec_pkg::OP_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // unlock sequence and address registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         key_stage <= 2'h0;
         unlocked  <= 1'b0;
      end else if (clk_en) begin
         unlocked  <= 1'b0;
         if (wr_key && bus.wdata[7:0] == npec_pkg::KEY_FIRST) begin
            key_stage <= 2'h1;
         end else if (wr_key && key_stage == 2'h1 &&
                      bus.wdata[7:0] == npec_pkg::KEY_SECOND) begin
            key_stage <= 2'h0;
            unlocked  <= 1'b1;
         end else if (bus.wr) begin
            key_stage <= 2'h0;
         end
      end
   end

   // address registers have no reset value
   always_ff @(posedge clk) begin
      if (clk_en && wr_upper) begin
         target_upper_addr <= bus.wdata[7:0];
      end
      if (clk_en && wr_lower) begin
         target_lower_addr <= bus.wdata;
      end
   end

   // ----------------------------------------------------------------
   // settle counter after idle exit
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         settle_cnt <= '0;
      end else if (clk_en) begin
         if (idle_exit) begin
            settle_cnt <= npec_pkg::CNT_W'(SETTLE_CYCLES);
         end else if (settling) begin
            settle_cnt <= settle_cnt - 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux; key reads zero, unused bits zero
   // ----------------------------------------------------------------
   wire [15:0] ctrl_view = {go, enable, fault, halt_in_idle_bit,
                            8'h00, operation_select};
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = npec_pkg::ZERO16;
      unique case (bus.addr)
         npec_pkg::ADDR_CONTROL:    rd_mux = ctrl_view;
         npec_pkg::ADDR_TGT_UPPER:  rd_mux = {npec_pkg::ZERO8,
                                              target_upper_addr};
         npec_pkg::ADDR_TGT_LOWER:  rd_mux = target_lower_addr;
         npec_pkg::ADDR_UNLOCK_KEY: rd_mux = npec_pkg::ZERO16;
      endcase
   end

   // ----------------------------------------------------------------
   // outputs, all registered
   // ----------------------------------------------------------------
   npec_pkg::npec_cmd_t cmd;
   assign cmd = '{start: go_ok, op: operation_select,
                  addr: {target_upper_addr, target_lower_addr}};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata      <= npec_pkg::ZERO16;
         nvm_start      <= 1'b0;
         nvm_op         <= npec_pkg::OP_RESET;
         nvm_addr       <= 24'h000000;
         nvm_halt       <= 1'b0;
         nvm_ready      <= 1'b0;
         power_save_ack <= 1'b0;
      end else if (clk_en) begin
         reg_rdata <= bus.rd ? rd_mux : npec_pkg::ZERO16;
         nvm_start <= cmd.start;
         if (cmd.start) begin
            nvm_op   <= cmd.op;
            nvm_addr <= cmd.addr;
         end
         nvm_halt  <= (next_state == ST_HALT);
         // idle_exit covers the edge before the settle count loads
         nvm_ready <= ~idle_s & ~settling & ~idle_exit;
         // soft resets also wait on go, via the same hold
         power_save_ack <= (psave_s | soft_reset) & ~go
                           & (next_state == ST_IDLE);
      end
   end

endmodule

`default_nettype wire

/* File: core/npec_pkg.sv */
// Purpose: shared constants and types of the flash program/erase controller
// Assumes: 16-bit register port, word-indexed register offsets
// Notes:   offsets are local choices; widths follow the register layout
package npec_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [1:0] ADDR_CONTROL    = 2'h0;
   localparam logic [1:0] ADDR_TGT_UPPER  = 2'h1;
   localparam logic [1:0] ADDR_TGT_LOWER  = 2'h2;
   localparam logic [1:0] ADDR_UNLOCK_KEY = 2'h3;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int BIT_GO         = 15;
   localparam int BIT_ENABLE     = 14;
   localparam int BIT_FAULT      = 13;
   localparam int BIT_HALT_IDLE  = 12;
   localparam int OP_MSB         = 3;

   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [7:0]  ZERO8  = 8'h00;
   localparam logic [3:0]  OP_RESET = 4'h0;

   // ----------------------------------------------------------------
   // unlock keys and operation codes
   // ----------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   localparam logic [3:0] OP_BULK_PRIMARY = 4'hD;
   localparam logic [3:0] OP_BULK_AUX     = 4'hA;
   localparam logic [3:0] OP_PAGE_ERASE   = 4'h3;
   localparam logic [3:0] OP_ROW_PROGRAM  = 4'h2;
   localparam logic [3:0] OP_DWORD_PROG   = 4'h1;
   localparam logic [3:0] OP_CONFIG_BYTE  = 4'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int SETTLE_TIME_NS  = 10000;
   localparam int SETTLE_CYCLES   =
      (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W           = 16;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } npec_bus_t;

   typedef struct packed {
      logic        start;
      logic [3:0]  op;
      logic [23:0] addr;
   } npec_cmd_t;

endpackage

/* File: tb/npec_ctrl_properties.sv */
// Purpose: concurrent checks on the controller's ports
// Assumes: one clock; reset_n is the only reset of the block
// Notes:   register contents are judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none

module npec_ctrl_checker #(
   parameter int SETTLE_CYCLES = 4
) (
   // clock, reset, enable
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        clk_en,
   // register port
   input wire logic [1:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // power state and array side
   input wire logic        idle_mode,
   input wire logic        power_save_ack,
   input wire logic        nvm_start,
   input wire logic [3:0]  nvm_op,
   input wire logic        nvm_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------
   // port relations
   // ----------------------------------------------------------------
   rdata_idle_a: assert property (!$past(reg_rd) && $past(clk_en)
      |-> reg_rdata == 16'h0000) else $error("read data without read");
   key_hidden_a: assert property ($past(reg_rd && clk_en && reg_addr ==
      npec_pkg::ADDR_UNLOCK_KEY) |-> reg_rdata == 16'h0000)
      else $error("key register readable");
   upper_byte_zero_a: assert property ($past(reg_rd && clk_en && reg_addr
      == npec_pkg::ADDR_TGT_UPPER) |-> reg_rdata[15:8] == 8'h00)
      else $error("upper address high byte not zero");
   ctrl_gap_zero_a: assert property ($past(reg_rd && clk_en && reg_addr ==
      npec_pkg::ADDR_CONTROL) |-> reg_rdata[11:4] == 8'h00)
      else $error("control bits 11 to 4 not zero");
   start_pulse_a: assert property (nvm_start |=> !nvm_start)
      else $error("start longer than one cycle");
   start_unlock_a: assert property (nvm_start |->
      $past(reg_wr && reg_addr == npec_pkg::ADDR_CONTROL && reg_wdata[15])
      && $past(reg_wr && reg_addr == npec_pkg::ADDR_UNLOCK_KEY
      && reg_wdata[7:0] == npec_pkg::KEY_SECOND, 2)
      && $past(reg_wr && reg_addr == npec_pkg::ADDR_UNLOCK_KEY
      && reg_wdata[7:0] == npec_pkg::KEY_FIRST, 3))
      else $error("start without exact unlock sequence");
   op_legal_a: assert property (nvm_start |-> nvm_op inside
      {4'hD, 4'hA, 4'h3, 4'h2, 4'h1, 4'h0})
      else $error("start with reserved operation");
   save_blocked_a: assert property (nvm_start |=> !power_save_ack)
      else $error("power save granted during operation");
   idle_not_ready_a: assert property (idle_mode [*4] |-> !nvm_ready)
      else $error("flash ready while idle");
   settle_wait_a: assert property ($rose(nvm_ready) |->
      !$past(idle_mode, SETTLE_CYCLES + 2))
      else $error("ready before settle");
   reset_quiet_a: assert property ($rose(reset_n) |-> !nvm_start
      && !nvm_ready && reg_rdata == 16'h0000)
      else $error("outputs active after reset");
endmodule

`default_nettype wire

/* File: tb/npec_ctrl_tb.sv */
// Purpose: self-checking bench of the program/erase controller
// Assumes: clk_en held high; array answers driven by the bench
// Notes:   settle count shortened to keep idle scenarios brief
`timescale 1ns/1ps
`default_nettype none

module npec_ctrl_tb;
   localparam int SETTLE = 4;
   logic        clk, reset_n, clk_en, reg_wr, reg_rd, sys_reset_req;
   logic        idle_mode, power_save_req, power_save_ack, nvm_start;
   logic        nvm_halt, nvm_ready, nvm_done, nvm_abnormal;
   logic [1:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [3:0]  nvm_op;
   logic [23:0] nvm_addr;
   int          fails, check_count, starts;

   npec_ctrl #(.SETTLE_CYCLES(SETTLE)) i_dut (.clk(clk), .reset_n(reset_n),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sys_reset_req(sys_reset_req), .idle_mode(idle_mode),
      .power_save_req(power_save_req), .power_save_ack(power_save_ack),
      .nvm_start(nvm_start), .nvm_op(nvm_op), .nvm_addr(nvm_addr),
      .nvm_halt(nvm_halt), .nvm_ready(nvm_ready), .nvm_done(nvm_done),
      .nvm_abnormal(nvm_abnormal));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (nvm_start === 1'b1) starts <= starts + 1;
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [23:0] seen,
                      input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // strobe stays high so unlock writes can run back to back
   task automatic drive(input logic [1:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      drive(a, d);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk);
   endtask
   task automatic start_op(input logic [15:0] cw, input int gap);
      drive(npec_pkg::ADDR_UNLOCK_KEY, 16'h0055);
      drive(npec_pkg::ADDR_UNLOCK_KEY, 16'h00AA);
      if (gap > 0) begin
         reg_wr <= 1'b0;
         @(posedge clk);
      end
      drive(npec_pkg::ADDR_CONTROL, cw);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   // array answer held three cycles for its synchroniser
   task automatic finish_op(input logic abn, output logic [15:0] v);
      if (abn) nvm_abnormal <= 1'b1;
      else nvm_done <= 1'b1;
      repeat (3) @(posedge clk);
      nvm_abnormal <= 1'b0;
      nvm_done <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         rd(npec_pkg::ADDR_CONTROL, v);
         if (v[15] === 1'b0) return;
      end
      fails++;
      wrap_up();
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [15:0] v;
      rd(npec_pkg::ADDR_CONTROL, v);
      chk("ctrl reset", v, 16'h0000);
      wr(npec_pkg::ADDR_TGT_UPPER, 16'hFFFF);
      wr(npec_pkg::ADDR_TGT_LOWER, 16'hA5C3);
      wr(npec_pkg::ADDR_UNLOCK_KEY, 16'h1234);
      wr(npec_pkg::ADDR_CONTROL, 16'h5FF3);
      rd(npec_pkg::ADDR_TGT_UPPER, v);
      chk("upper", v, 16'h00FF);
      rd(npec_pkg::ADDR_TGT_LOWER, v);
      chk("lower", v, 16'hA5C3);
      rd(npec_pkg::ADDR_UNLOCK_KEY, v);
      chk("key", v, 16'h0000);
      rd(npec_pkg::ADDR_CONTROL, v);
      chk("ctrl gap", v, 16'h5003);
   endtask
   task automatic t_launch();
      logic [3:0]  ops [6] = '{4'hD, 4'hA, 4'h3, 4'h2, 4'h1, 4'h0};
      logic [15:0] v;
      int          s;
      power_save_req <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(npec_pkg::ADDR_TGT_UPPER, {8'h00, 8'hC0 + 8'(i)});
         wr(npec_pkg::ADDR_TGT_LOWER, 16'h5A00 + 16'(i));
         // operation is selected before go is set
         wr(npec_pkg::ADDR_CONTROL, {12'h400, ops[i]});
         s = starts;
         start_op({12'hC00, ops[i]}, 0);
         #1 chk("start", 24'(starts - s), 1);
         chk("op", nvm_op, ops[i]);
         chk("addr", nvm_addr, {8'hC0 + 8'(i), 16'h5A00 + 16'(i)});
         wr(npec_pkg::ADDR_CONTROL, 16'h0000);
         rd(npec_pkg::ADDR_CONTROL, v);
         chk("go held", v, {12'hC00, ops[i]});
         chk("ack busy", power_save_ack, 0);
         finish_op(1'b0, v);
         chk("done", v, {12'h400, ops[i]});
         repeat (4) @(posedge clk);
         #1 chk("ack free", power_save_ack, 1);
      end
      power_save_req <= 1'b0;
   endtask
   task automatic t_refused();
      logic [15:0] cw [6] = '{16'hC00F, 16'hC00E, 16'hC00C, 16'hC00B,
                              16'h8003, 16'hC003};
      logic [15:0] v;
      int          s;
      for (int i = 0; i < 6; i++) begin
         wr(npec_pkg::ADDR_CONTROL, {1'b0, cw[i][14:0]});
         s = starts;
         start_op(cw[i], (i == 5) ? 1 : 0);
         repeat (8) @(posedge clk);
         chk("no start", 24'(starts - s), 0);
         rd(npec_pkg::ADDR_CONTROL, v);
         chk("fault", {v[15], v[13]}, 2'b01);
      end
      wr(npec_pkg::ADDR_CONTROL, 16'h4000);
   endtask
   task automatic t_abnormal();
      logic [15:0] v;
      wr(npec_pkg::ADDR_CONTROL, 16'h4001);
      start_op(16'hC001, 0);
      finish_op(1'b1, v);
      chk("abort fault", v, 16'h6001);
      wr(npec_pkg::ADDR_CONTROL, 16'h4000);
   endtask
   task automatic t_resets();
      logic [15:0] v;
      wr(npec_pkg::ADDR_CONTROL, 16'h5002);
      sys_reset_req <= 1'b1;
      repeat (6) @(posedge clk);
      sys_reset_req <= 1'b0;
      rd(npec_pkg::ADDR_CONTROL, v);
      chk("sys reset", v, 16'h5002);
      start_op(16'hD002, 0);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(npec_pkg::ADDR_CONTROL, v);
      chk("abort", v, 16'h0000);
   endtask
   task automatic t_idle(input logic hbit);
      logic [15:0] v;
      wr(npec_pkg::ADDR_CONTROL, {3'b010, hbit, 12'h003});
      start_op({3'b110, hbit, 12'h003}, 0);
      idle_mode <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("halt", nvm_halt, hbit);
      chk("idle ready", nvm_ready, 0);
      idle_mode <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("settling", nvm_ready, 0);
      for (int i = 0; i < 30 && nvm_ready !== 1'b1; i++) @(posedge clk);
      #1 chk("ready", nvm_ready, 1);
      finish_op(1'b0, v);
      chk("idle done", v, {3'b010, hbit, 12'h003});
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {reset_n, reg_wr, reg_rd, sys_reset_req, idle_mode} = 5'h00;
      {power_save_req, nvm_done, nvm_abnormal} = 3'h0;
      clk_en = 1'b1;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      {fails, check_count, starts} = '0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_launch();
      t_refused();
      t_abnormal();
      t_resets();
      t_idle(1'b1);
      t_idle(1'b0);
      wrap_up();
   end
endmodule

bind npec_ctrl npec_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
   .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .idle_mode(idle_mode),
   .power_save_ack(power_save_ack), .nvm_start(nvm_start),
   .nvm_op(nvm_op), .nvm_ready(nvm_ready));

`default_nettype wire
